// File: design/viri_pkg.sv
/*
 * constants and types of the vectored interrupt controller register block.
 * assumes a 32-bit classic wishbone bus and 32 interrupt sources.
 */
package viri_pkg;

    localparam int          NUM_SRC   = 32;
    localparam logic [19:0] BASE_PAGE = 20'hfffff;

    localparam logic [11:0] OFS_MODE_FIRST = 12'h000;
    localparam logic [11:0] OFS_MODE_LAST  = 12'h07c;
    localparam logic [11:0] OFS_VEC_FIRST  = 12'h080;
    localparam logic [11:0] OFS_VEC_LAST   = 12'h0fc;
    localparam logic [11:0] OFS_NVR        = 12'h100;
    localparam logic [11:0] OFS_FVR        = 12'h104;
    localparam logic [11:0] OFS_CUR        = 12'h108;
    localparam logic [11:0] OFS_PEND       = 12'h10c;
    localparam logic [11:0] OFS_MASK       = 12'h110;
    localparam logic [11:0] OFS_CORE       = 12'h114;
    localparam logic [11:0] OFS_RSV0       = 12'h118;
    localparam logic [11:0] OFS_RSV1       = 12'h11c;
    localparam logic [11:0] OFS_EN_CMD     = 12'h120;
    localparam logic [11:0] OFS_DIS_CMD    = 12'h124;
    localparam logic [11:0] OFS_CLR_CMD    = 12'h128;
    localparam logic [11:0] OFS_SET_CMD    = 12'h12c;
    localparam logic [11:0] OFS_EOS_CMD    = 12'h130;
    localparam logic [11:0] OFS_SPU        = 12'h134;
    localparam logic [11:0] OFS_DBG        = 12'h138;
    localparam logic [11:0] OFS_RSV2       = 12'h13c;
    localparam logic [11:0] OFS_FR_EN      = 12'h140;
    localparam logic [11:0] OFS_FR_DIS     = 12'h144;
    localparam logic [11:0] OFS_FR_STS     = 12'h148;
    localparam logic [11:0] OFS_EV_STS     = 12'h150;
    localparam logic [11:0] OFS_EV_CLR     = 12'h154;
    localparam logic [11:0] OFS_EV_EN      = 12'h158;

    // source mode fields
    localparam int PRIO_LSB = 0;
    localparam int TYPE_LSB = 5;
    // debug control fields
    localparam int DBG_PROTECT = 0;
    localparam int DBG_GMASK   = 1;
    // core line status fields
    localparam int CORE_FAST   = 0;
    localparam int CORE_NORMAL = 1;
    // event status fields
    localparam int EV_SPURIOUS = 0;
    localparam int EV_NORMAL   = 1;
    localparam int EV_FAST     = 2;
    localparam int EV_W        = 3;

    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [31:0] EXT_SRC   = 32'h4000_0001;

    typedef struct packed {
        logic [1:0] trigger_type;
        logic [2:0] priority_level;
    } viri_mode_t;

    localparam viri_mode_t RST_MODE = '{trigger_type: 2'h0, priority_level: 3'h0};

endpackage

// File: design/viri_top.sv
/*
 * register interface and interrupt routing of a 32-source vectored
 * interrupt controller, one wishbone classic slave.
 * assumes sources are synchronous to clk_i; ext_src mask marks external ones.
 */
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module viri_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [31:0] src_i,
    output logic             normal_interrupt_line_n_o,
    output logic             fast_interrupt_line_n_o,
    output logic             irq_o
);

    // ****************************************************************
    // storage
    // ****************************************************************
    viri_pkg::viri_mode_t  source_mode [viri_pkg::NUM_SRC];
    logic [31:0]           source_vector [viri_pkg::NUM_SRC];
    logic [31:0]           spurious_vector;
    logic [31:0]           debug_control;
    logic [31:0]           mask_status;
    logic [31:0]           pending_status;
    logic [31:0]           fast_redirect_status;
    logic [31:0]           src_prev;
    logic [4:0]            current_source_number;
    logic [2:0]            cur_prio;
    logic                  cur_valid;
    logic [viri_pkg::EV_W-1:0] ev_sts;
    logic [viri_pkg::EV_W-1:0] ev_en;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic        req;
    logic        hit;
    logic        wr;
    logic        rd;
    logic [11:0] ofs;
    logic [4:0]  idx;
    logic [31:0] wmask;
    logic [31:0] wdata;

    assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign hit   = wb_adr_i[31:12] == viri_pkg::BASE_PAGE;
    assign ofs   = {wb_adr_i[11:2], 2'h0};
    assign idx   = wb_adr_i[6:2];
    assign wr    = req & hit & wb_we_i;
    assign rd    = req & hit & ~wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdata = wb_dat_i & wmask;

    logic wr_mode;
    logic wr_vec;
    logic wr_en;
    logic wr_dis;
    logic wr_clr;
    logic wr_set;
    logic wr_eos;
    logic wr_nvr;
    logic rd_nvr;
    logic rd_fvr;

    assign wr_mode = wr & (ofs <= viri_pkg::OFS_MODE_LAST);
    assign wr_vec  = wr & (ofs >= viri_pkg::OFS_VEC_FIRST)
                        & (ofs <= viri_pkg::OFS_VEC_LAST);
    assign wr_en   = wr & (ofs == viri_pkg::OFS_EN_CMD);
    assign wr_dis  = wr & (ofs == viri_pkg::OFS_DIS_CMD);
    assign wr_clr  = wr & (ofs == viri_pkg::OFS_CLR_CMD);
    assign wr_set  = wr & (ofs == viri_pkg::OFS_SET_CMD);
    assign wr_eos  = wr & (ofs == viri_pkg::OFS_EOS_CMD);
    assign wr_nvr  = wr & (ofs == viri_pkg::OFS_NVR);
    assign rd_nvr  = rd & (ofs == viri_pkg::OFS_NVR);
    assign rd_fvr  = rd & (ofs == viri_pkg::OFS_FVR);

    // ****************************************************************
    // source conditioning
    // ****************************************************************
    logic [31:0] is_edge;
    logic [31:0] active_lvl;
    logic [31:0] edge_seen;

    always_comb begin
        for (int i = 0; i < viri_pkg::NUM_SRC; i++) begin
            is_edge[i] = source_mode[i].trigger_type[0];
            if (viri_pkg::EXT_SRC[i] && !source_mode[i].trigger_type[1]) begin
                active_lvl[i] = ~src_i[i];
            end else begin
                active_lvl[i] = src_i[i];
            end
        end
    end

    // previous active level, for edge detection in either polarity on external sources, rising only on the others
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_prev <= viri_pkg::RST_WORD;
        end else begin
            src_prev <= active_lvl;
        end
    end

    assign edge_seen = active_lvl & ~src_prev;

    // ****************************************************************
    // arbitration
    // ****************************************************************
    logic [31:0] ready;
    logic [4:0]  best_idx;
    logic [2:0]  best_prio;
    logic        best_valid;
    logic        take_normal;
    logic        fast_req;

    assign ready = pending_status & mask_status & ~fast_redirect_status;

    always_comb begin
        best_idx   = 5'h00;
        best_prio  = 3'h0;
        best_valid = 1'b0;
        // source 0 never competes
        for (int i = 1; i < viri_pkg::NUM_SRC; i++) begin
            if (ready[i] && (!best_valid
                    || source_mode[i].priority_level > best_prio)) begin
                best_idx   = 5'(i);
                best_prio  = source_mode[i].priority_level;
                best_valid = 1'b1;
            end
        end
    end

    assign take_normal = best_valid & (~cur_valid | (best_prio > cur_prio));
    assign fast_req    = (pending_status[0] & mask_status[0])
                       | |(pending_status & mask_status & fast_redirect_status);

    // acknowledge on readout read, or only on its write in protect mode
    logic ack_normal;
    assign ack_normal = take_normal & (debug_control[viri_pkg::DBG_PROTECT]
                                       ? wr_nvr : rd_nvr);

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < viri_pkg::NUM_SRC; i++) begin
                source_mode[i]   <= viri_pkg::RST_MODE;
                source_vector[i] <= viri_pkg::RST_WORD;
            end
        end else if (wr_mode) begin
            source_mode[idx] <= (source_mode[idx] & ~viri_pkg::viri_mode_t'({wmask[6:5], wmask[2:0]}))
                             | viri_pkg::viri_mode_t'({wdata[6:5], wdata[2:0]});
        end else if (wr_vec) begin
            source_vector[idx] <= (source_vector[idx] & ~wmask) | wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spurious_vector <= viri_pkg::RST_WORD;
            debug_control   <= viri_pkg::RST_WORD;
        end else if (wr && ofs == viri_pkg::OFS_SPU) begin
            spurious_vector <= (spurious_vector & ~wmask) | wdata;
        end else if (wr && ofs == viri_pkg::OFS_DBG) begin
            debug_control <= {30'h0, (debug_control[1:0] & ~wmask[1:0]) | wdata[1:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_status <= viri_pkg::RST_WORD;
        end else if (wr_en) begin
            mask_status <= mask_status | wdata;
        end else if (wr_dis) begin
            mask_status <= mask_status & ~wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_redirect_status <= viri_pkg::RST_WORD;
        end else if (wr && ofs == viri_pkg::OFS_FR_EN) begin
            fast_redirect_status <= fast_redirect_status | wdata;
        end else if (wr && ofs == viri_pkg::OFS_FR_DIS) begin
            fast_redirect_status <= fast_redirect_status & ~wdata;
        end
    end

    // ****************************************************************
    // pending state
    // ****************************************************************
    logic [31:0] ack_clr;

    always_comb begin
        ack_clr = 32'h0;
        if (ack_normal) begin
            ack_clr[best_idx] = 1'b1;
        end
        // a fast readout clears source 0 only, never a redirected one
        if (rd_fvr && pending_status[0] && mask_status[0]) begin
            ack_clr[0] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_status <= src_i & viri_pkg::EXT_SRC;
        end else begin
            for (int i = 0; i < viri_pkg::NUM_SRC; i++) begin
                if (is_edge[i]) begin
                    // edge or software set wins over any clear
                    pending_status[i] <= (pending_status[i]
                                          & ~(ack_clr[i] | (wr_clr & wdata[i])))
                                       | edge_seen[i] | (wr_set & wdata[i]);
                end else begin
                    pending_status[i] <= active_lvl[i];
                end
            end
        end
    end

    // ****************************************************************
    // current source
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            current_source_number <= 5'h00;
            cur_prio              <= 3'h0;
            cur_valid             <= 1'b0;
        end else if (ack_normal) begin
            current_source_number <= best_idx;
            cur_prio              <= best_prio;
            cur_valid             <= 1'b1;
        end else if (wr_eos) begin
            cur_valid <= 1'b0;
            cur_prio  <= 3'h0;
        end
    end

    // ****************************************************************
    // core lines
    // ****************************************************************
    logic normal_on;
    logic fast_on;

    assign normal_on = take_normal & ~debug_control[viri_pkg::DBG_GMASK];
    assign fast_on   = fast_req & ~debug_control[viri_pkg::DBG_GMASK];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            normal_interrupt_line_n_o <= 1'b1;
            fast_interrupt_line_n_o   <= 1'b1;
        end else begin
            normal_interrupt_line_n_o <= ~normal_on;
            fast_interrupt_line_n_o   <= ~fast_on;
        end
    end

    // ****************************************************************
    // event status
    // ****************************************************************
    logic [viri_pkg::EV_W-1:0] ev_set;

    always_comb begin
        ev_set = '0;
        ev_set[viri_pkg::EV_SPURIOUS] = rd_nvr & ~take_normal;
        ev_set[viri_pkg::EV_NORMAL]   = normal_on & normal_interrupt_line_n_o;
        ev_set[viri_pkg::EV_FAST]     = fast_on & fast_interrupt_line_n_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_sts <= '0;
        end else begin
            ev_sts <= (ev_sts & ~((wr && ofs == viri_pkg::OFS_EV_CLR)
                                  ? wdata[viri_pkg::EV_W-1:0] : '0)) | ev_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_en <= '0;
        end else if (wr && ofs == viri_pkg::OFS_EV_EN) begin
            ev_en <= (ev_en & ~wmask[viri_pkg::EV_W-1:0]) | wdata[viri_pkg::EV_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(ev_sts & ev_en);
        end
    end

    // ****************************************************************
    // read mux and acknowledge
    // ****************************************************************
    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0;
        if (ofs <= viri_pkg::OFS_MODE_LAST) begin
            rdata[6:5] = source_mode[idx].trigger_type;
            rdata[2:0] = source_mode[idx].priority_level;
        end else if (ofs <= viri_pkg::OFS_VEC_LAST) begin
            rdata = source_vector[idx];
        end else begin
            unique case (ofs)
                viri_pkg::OFS_NVR:    rdata = take_normal ? source_vector[best_idx]
                                                          : spurious_vector;
                viri_pkg::OFS_FVR:    rdata = fast_req ? source_vector[0]
                                                       : spurious_vector;
                viri_pkg::OFS_CUR:    rdata = {27'h0, current_source_number};
                viri_pkg::OFS_PEND:   rdata = pending_status;
                viri_pkg::OFS_MASK:   rdata = mask_status;
                viri_pkg::OFS_CORE:   rdata = {30'h0, ~normal_interrupt_line_n_o,
                                               ~fast_interrupt_line_n_o};
                viri_pkg::OFS_SPU:    rdata = spurious_vector;
                viri_pkg::OFS_DBG:    rdata = debug_control;
                viri_pkg::OFS_FR_STS: rdata = fast_redirect_status;
                viri_pkg::OFS_EV_STS: rdata = {29'h0, ev_sts};
                viri_pkg::OFS_EV_EN:  rdata = {29'h0, ev_en};
                default:              rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= rd ? rdata : 32'h0;
        end
    end

endmodule // viri_top

// File: tb/viri_checker.sv
/* bus and line checker for viri_top.
   assumes a bind into viri_top and synchronous active-high rst_i. */
`timescale 1ns/1ps
module viri_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [31:0] src_i,
    input wire logic        normal_interrupt_line_n_o,
    input wire logic        fast_interrupt_line_n_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [11:0] ofs;
    logic        in_win;
    assign ofs    = {wb_adr_i[11:2], 2'h0};
    assign in_win = wb_adr_i[31:12] == viri_pkg::BASE_PAGE;
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_read;
        s_take ##0 !wb_we_i;
    endsequence
    property p_ack_next;
        s_take |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("request not answered next cycle");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_out_win;
        s_read ##0 !in_win |=> wb_dat_o == 32'h0;
    endproperty
    a_out_win: assert property (p_out_win)
        else $error("read outside window not zero");
    property p_rsv_zero;
        s_read ##0 (in_win && (ofs == 12'h118 || ofs == 12'h11c || ofs == 12'h13c))
            |=> wb_dat_o == 32'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved read not zero");
    property p_cmd_zero;
        s_read ##0 (in_win && ofs >= 12'h120 && ofs <= 12'h130) |=> wb_dat_o == 32'h0;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero)
        else $error("command read not zero");
    property p_ff_zero;
        s_read ##0 (in_win && (ofs == 12'h140 || ofs == 12'h144)) |=> wb_dat_o == 32'h0;
    endproperty
    a_ff_zero: assert property (p_ff_zero)
        else $error("redirect command read not zero");
    property p_rst_lines;
        disable iff (1'b0)
        rst_i |=> normal_interrupt_line_n_o && fast_interrupt_line_n_o && !irq_o;
    endproperty
    a_rst_lines: assert property (p_rst_lines)
        else $error("lines active after reset");
endmodule // viri_checker

bind viri_top viri_checker u_viri_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_i(src_i), .irq_o(irq_o),
    .normal_interrupt_line_n_o(normal_interrupt_line_n_o),
    .fast_interrupt_line_n_o(fast_interrupt_line_n_o));

// File: tb/viri_core_model.sv
/* core side: samples both active-low lines as the core would.
   assumes the controller clock. */
`timescale 1ns/1ps
module viri_core_model (
    input  wire logic clk_i,
    input  wire logic normal_interrupt_line_n_i,
    input  wire logic fast_interrupt_line_n_i,
    output logic      normal_seen_o,
    output logic      fast_seen_o
);
    always_ff @(posedge clk_i) begin
        normal_seen_o <= !normal_interrupt_line_n_i;
        fast_seen_o   <= !fast_interrupt_line_n_i;
    end
endmodule // viri_core_model

// File: tb/viri_top_test.sv
/* self-checking bench of viri_top with a core model.
   assumes the checker is bound into viri_top. */
`timescale 1ns/1ps
module viri_top_test;
    logic        clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic [31:0] wb_adr_i = 0, wb_dat_i = 0, src_i = 0, wb_dat_o, r;
    logic [3:0]  wb_sel_i = 4'hf;
    logic        wb_ack_o, nl_n, fl_n, irq_o, n_seen, f_seen;
    logic [31:0] exp_q[$];
    logic [31:0] vec[32];
    int          n_fail = 0, samples_checked = 0, seed = 59, k;
    viri_top u_viri_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_i(src_i),
        .normal_interrupt_line_n_o(nl_n), .fast_interrupt_line_n_o(fl_n), .irq_o(irq_o));
    viri_core_model u_viri_core_model (.clk_i(clk_i), .normal_interrupt_line_n_i(nl_n),
        .fast_interrupt_line_n_i(fl_n), .normal_seen_o(n_seen), .fast_seen_o(f_seen));
    initial forever #2.5 clk_i = ~clk_i;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task wb_cycle(input logic [11:0] o, input logic we, input logic [31:0] d,
                  input logic [19:0] page);
        int i;
        wb_adr_i <= {page, o};
        wb_we_i  <= we;
        wb_dat_i <= d;
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 50);
        if (i >= 50) begin
            n_fail++;
            report_and_stop;
        end
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        wb_we_i  <= 0;
        @(posedge clk_i);
    endtask
    task wr(input logic [11:0] o, input logic [31:0] d);
        wb_cycle(o, 1'b1, d, viri_pkg::BASE_PAGE);
    endtask
    task rd(input logic [11:0] o, input logic [31:0] e);
        exp_q.push_back(e);
        wb_cycle(o, 1'b0, 32'h0, viri_pkg::BASE_PAGE);
    endtask
    // which: 0 normal seen, 1 fast seen, 2 irq
    task wait_out(input int which, input logic val);
        int  i;
        logic s;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            s = (which == 0) ? n_seen : (which == 1) ? f_seen : irq_o;
            if (s === val) break;
        end
        check({31'h0, s}, {31'h0, val});
        if (i == 20) report_and_stop;
    endtask
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            check(wb_dat_o, exp_q.pop_front());
        end
    end
    initial begin
        repeat (50000) @(posedge clk_i);
        n_fail++;
        report_and_stop;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        for (k = 0; k < 32; k++) begin
            rd(12'(k * 4), 32'h0);
            rd(12'(128 + k * 4), 32'h0);
        end
        // low-level external sources 0 and 30 read pending with inputs low
        for (k = 0; k < 8; k++) begin
            rd(12'(264 + k * 4), (k == 1) ? 32'h4000_0001 : 32'h0);
        end
        rd(12'h138, 32'h0);
        rd(12'h148, 32'h0);
        rd(12'h13c, 32'h0);
        rd(12'h140, 32'h0);
        rd(12'h144, 32'h0);
        for (k = 0; k < 32; k++) begin
            r = ($random(seed) & 32'h7) | (32'(k % 4) << 5);
            wr(12'(k * 4), r);
            rd(12'(k * 4), r);
            vec[k] = $random(seed);
            wr(12'(128 + k * 4), vec[k]);
            rd(12'(128 + k * 4), vec[k]);
        end
        r = $random(seed);
        wr(12'h134, r);
        rd(12'h100, r);
        rd(12'h104, r);
        wr(12'h138, 32'h2);
        rd(12'h138, 32'h2);
        wr(12'h138, 32'h0);
        wr(12'h108, 32'hffff_ffff);
        wr(12'h118, 32'hffff_ffff);
        rd(12'h108, 32'h0);
        rd(12'h118, 32'h0);
        wb_cycle(12'h134, 1'b1, ~r, 20'h0);
        rd(12'h134, r);
        exp_q.push_back(32'h0);
        wb_cycle(12'h134, 1'b0, 32'h0, 20'h0);
        wr(12'h140, 32'hf0f0_00f0);
        wr(12'h144, 32'h3000_0030);
        rd(12'h148, 32'hc0f0_00c0);
        wr(12'h144, 32'hffff_ffff);
        rd(12'h148, 32'h0);
        wr(12'h000, 32'h60);
        wr(12'h128, 32'h1);
        wr(12'h014, 32'h3);
        wr(12'h024, 32'h6);
        src_i <= 32'h220;
        wr(12'h120, 32'h220);
        wait_out(0, 1'b1);
        rd(12'h110, 32'h220);
        rd(12'h10c, 32'h220);
        rd(12'h100, vec[9]);
        rd(12'h108, 32'h9);
        wait_out(0, 1'b0);
        wr(12'h130, 32'h0);
        wait_out(0, 1'b1);
        // general mask forces the line inactive
        wr(12'h138, 32'h2);
        wait_out(0, 1'b0);
        wr(12'h138, 32'h0);
        wait_out(0, 1'b1);
        src_i <= 32'h20;
        repeat (2) @(posedge clk_i);
        // protect mode: a readout read leaves the current source alone
        wr(12'h138, 32'h1);
        rd(12'h100, vec[5]);
        rd(12'h108, 32'h9);
        wr(12'h138, 32'h0);
        rd(12'h100, vec[5]);
        rd(12'h108, 32'h5);
        wr(12'h130, 32'h0);
        // protect mode: a readout write acknowledges
        wr(12'h138, 32'h1);
        wr(12'h100, 32'h0);
        wait_out(0, 1'b0);
        wr(12'h130, 32'h0);
        wr(12'h138, 32'h0);
        src_i <= 32'h0;
        wr(12'h124, 32'h220);
        rd(12'h110, 32'h0);
        wait_out(0, 1'b0);
        wr(12'h01c, 32'h66);
        wr(12'h12c, 32'h80);
        rd(12'h10c, 32'h80);
        wr(12'h128, 32'h80);
        rd(12'h10c, 32'h0);
        wr(12'h000, 32'h67);
        wr(12'h120, 32'h1);
        wr(12'h12c, 32'h1);
        wait_out(1, 1'b1);
        rd(12'h104, vec[0]);
        wait_out(1, 1'b0);
        rd(12'h104, r);
        wr(12'h124, 32'h1);
        wr(12'h02c, 32'h3);
        wr(12'h140, 32'h800);
        src_i <= 32'h800;
        wr(12'h120, 32'h800);
        wait_out(1, 1'b1);
        check({31'h0, n_seen}, 32'h0);
        rd(12'h104, vec[0]);
        src_i <= 32'h0;
        wr(12'h124, 32'h800);
        wr(12'h144, 32'h800);
        wait_out(1, 1'b0);
        wr(12'h154, 32'h7);
        wr(12'h158, 32'h1);
        rd(12'h158, 32'h1);
        wait_out(2, 1'b0);
        rd(12'h100, r);
        wait_out(2, 1'b1);
        rd(12'h150, 32'h1);
        wr(12'h154, 32'h1);
        wait_out(2, 1'b0);
        report_and_stop;
    end
endmodule // viri_top_test
